//--- rtl/flag_skip_pkg.sv
// Package: opcodes, bit positions and carriers for the flag skip tests
package flag_skip_pkg;
  localparam int OPC_W = 10;
  localparam logic [9:0] OPC_CONV_DONE = 10'h287;
  localparam logic [9:0] OPC_EXT_PIN = 10'h03A;
  localparam logic [9:0] OPC_POWERDOWN = 10'h003;
  localparam logic [9:0] OPC_SERIAL = 10'h288;
  localparam int CONV_IRQ_EN_BIT = 2;
  localparam int SERIAL_IRQ_EN_BIT = 3;
  localparam int EXT_POL_BIT = 2;
  localparam int CTRL_W = 4;

  typedef enum logic [2:0] {
    op_none,
    op_conv_done,
    op_ext_pin,
    op_powerdown,
    op_serial
  } skip_op_t;

  typedef struct packed {
    logic skip;
    logic clr_conv;
    logic clr_serial;
    logic hit;
  } skip_result_t;

  typedef struct packed {
    skip_op_t op;
    skip_result_t res;
  } skip_state_t;
endpackage : flag_skip_pkg

//--- rtl/flag_skip_test_instructions.sv
// Decode and execute of the four single-word conditional-skip flag tests
`timescale 1ns/10ps

// Function
// - Conversion test skips on flag, clears it
// - Conversion test is no-op when enabled
// - Pin test skips on level per polarity
// - Power-down test skips on flag, keeps it
// - Serial test skips on flag, clears it
// - Serial test is no-op when enabled
module flag_skip_test_instructions (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic instr_valid,
  input wire logic [flag_skip_pkg::OPC_W-1:0] instr_opcode,
  input wire logic [flag_skip_pkg::CTRL_W-1:0] second_irq_control_reg,
  input wire logic [flag_skip_pkg::CTRL_W-1:0] ext_irq_control_reg,
  input wire logic conversion_done_flag,
  input wire logic serial_request_flag,
  input wire logic powerdown_flag,
  input wire logic ext_pin_level,
  output logic skip_next,
  output logic clear_conversion_done,
  output logic clear_serial_request,
  output logic decoded,
  output logic carry_write_en
);
  flag_skip_pkg::skip_state_t state_ff;
  flag_skip_pkg::skip_state_t nxt_state;
  logic conv_en;
  logic ser_en;
  logic pol;

  assign conv_en = second_irq_control_reg[flag_skip_pkg::CONV_IRQ_EN_BIT];
  assign ser_en = second_irq_control_reg[flag_skip_pkg::SERIAL_IRQ_EN_BIT];
  assign pol = ext_irq_control_reg[flag_skip_pkg::EXT_POL_BIT];

  // Result registered: the fetch decides in one instruction cycle
  always_comb
  begin
    nxt_state = '0;
    nxt_state.op = flag_skip_pkg::op_none;
    if (instr_valid)
    begin
      unique case (instr_opcode)
        flag_skip_pkg::OPC_CONV_DONE:
        begin
          nxt_state.op = flag_skip_pkg::op_conv_done;
          nxt_state.res.hit = 1'b1;
          if (!conv_en)
          begin
            nxt_state.res.skip = conversion_done_flag;
            nxt_state.res.clr_conv = 1'b1;
          end
        end
        flag_skip_pkg::OPC_EXT_PIN:
        begin
          nxt_state.op = flag_skip_pkg::op_ext_pin;
          nxt_state.res.hit = 1'b1;
          nxt_state.res.skip = (ext_pin_level == pol);
        end
        flag_skip_pkg::OPC_POWERDOWN:
        begin
          nxt_state.op = flag_skip_pkg::op_powerdown;
          nxt_state.res.hit = 1'b1;
          nxt_state.res.skip = powerdown_flag;
        end
        flag_skip_pkg::OPC_SERIAL:
        begin
          nxt_state.op = flag_skip_pkg::op_serial;
          nxt_state.res.hit = 1'b1;
          if (!ser_en)
          begin
            nxt_state.res.skip = serial_request_flag;
            nxt_state.res.clr_serial = 1'b1;
          end
        end
        default:
        begin
          nxt_state.op = flag_skip_pkg::op_none;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      state_ff <= '0;
    else
      state_ff <= nxt_state;
  end

  assign skip_next = state_ff.res.skip;
  assign clear_conversion_done = state_ff.res.clr_conv;
  assign clear_serial_request = state_ff.res.clr_serial;
  assign decoded = state_ff.res.hit;
  // Never touches carry
  assign carry_write_en = 1'b0;

  // Fetch decode seen by the checks, kept apart from the state struct
  logic fetch_conv;
  logic fetch_pin;
  logic fetch_pd;
  logic fetch_serial;
  logic fetch_any;
  logic fetch_other;

  assign fetch_conv = instr_valid && (instr_opcode == flag_skip_pkg::OPC_CONV_DONE);
  assign fetch_pin = instr_valid && (instr_opcode == flag_skip_pkg::OPC_EXT_PIN);
  assign fetch_pd = instr_valid && (instr_opcode == flag_skip_pkg::OPC_POWERDOWN);
  assign fetch_serial = instr_valid && (instr_opcode == flag_skip_pkg::OPC_SERIAL);
  assign fetch_any = fetch_conv || fetch_pin || fetch_pd || fetch_serial;
  assign fetch_other = instr_valid && !fetch_any;

  // Every answer stands in the cycle right after its fetch
  chk_conv_skip_clear: assert property (@(posedge mclk) disable iff (!arst_n)
    fetch_conv && !conv_en
    |=> clear_conversion_done && skip_next == $past(conversion_done_flag))
    else $error("conversion test wrong");

  chk_conv_nop: assert property (@(posedge mclk) disable iff (!arst_n)
    fetch_conv && conv_en
    |=> !clear_conversion_done && !skip_next && decoded && !clear_serial_request)
    else $error("conversion test not a no-op");

  chk_conv_decoded: assert property (@(posedge mclk) disable iff (!arst_n)
    fetch_conv && !conv_en
    |=> decoded && !clear_serial_request)
    else $error("conversion test touched serial flag");

  chk_pin_level: assert property (@(posedge mclk) disable iff (!arst_n)
    fetch_pin
    |=> skip_next == ($past(ext_pin_level) == $past(pol)))
    else $error("pin test wrong");

  chk_pin_decoded: assert property (@(posedge mclk) disable iff (!arst_n)
    fetch_pin
    |=> decoded)
    else $error("pin test not decoded");

  chk_pin_no_clear: assert property (@(posedge mclk) disable iff (!arst_n)
    fetch_pin
    |=> !clear_conversion_done && !clear_serial_request)
    else $error("pin test cleared a flag");

  chk_pd_keep: assert property (@(posedge mclk) disable iff (!arst_n)
    fetch_pd
    |=> skip_next == $past(powerdown_flag) && !clear_conversion_done
        && !clear_serial_request)
    else $error("power-down test wrong");

  chk_pd_decoded: assert property (@(posedge mclk) disable iff (!arst_n)
    fetch_pd
    |=> decoded)
    else $error("power-down test not decoded");

  chk_serial_clear: assert property (@(posedge mclk) disable iff (!arst_n)
    fetch_serial && !ser_en
    |=> clear_serial_request && skip_next == $past(serial_request_flag))
    else $error("serial test wrong");

  chk_serial_decoded: assert property (@(posedge mclk) disable iff (!arst_n)
    fetch_serial && !ser_en
    |=> decoded && !clear_conversion_done)
    else $error("serial test touched conversion flag");

  chk_serial_nop: assert property (@(posedge mclk) disable iff (!arst_n)
    fetch_serial && ser_en
    |=> !clear_serial_request && !skip_next && decoded && !clear_conversion_done)
    else $error("serial test not a no-op");

  chk_clear_conv_src: assert property (@(posedge mclk) disable iff (!arst_n)
    clear_conversion_done
    |-> state_ff.op == flag_skip_pkg::op_conv_done)
    else $error("conversion clear from wrong instruction");

  chk_clear_ser_src: assert property (@(posedge mclk) disable iff (!arst_n)
    clear_serial_request
    |-> state_ff.op == flag_skip_pkg::op_serial)
    else $error("serial clear from wrong instruction");

  chk_one_cycle: assert property (@(posedge mclk) disable iff (!arst_n)
    fetch_any
    |=> decoded ##1 (decoded == $past(fetch_any)))
    else $error("result held beyond one cycle");

  chk_back_to_back: assert property (@(posedge mclk) disable iff (!arst_n)
    fetch_any ##1 fetch_any
    |=> decoded && $past(decoded))
    else $error("back to back results missing");

  chk_decode_exact: assert property (@(posedge mclk) disable iff (!arst_n)
    1'b1
    |=> decoded == $past(fetch_any))
    else $error("decode differs from fetched word");

  chk_other_quiet: assert property (@(posedge mclk) disable iff (!arst_n)
    fetch_other
    |=> !decoded && !skip_next && !clear_conversion_done
        && !clear_serial_request)
    else $error("foreign opcode gave a result");

  chk_idle_quiet: assert property (@(posedge mclk) disable iff (!arst_n)
    !instr_valid
    |=> !skip_next && !decoded && !clear_conversion_done && !clear_serial_request)
    else $error("result without instruction");

  chk_carry_quiet: assert property (@(posedge mclk) disable iff (!arst_n)
    !carry_write_en)
    else $error("carry write enabled");

  chk_skip_needs_hit: assert property (@(posedge mclk) disable iff (!arst_n)
    skip_next
    |-> decoded)
    else $error("skip without decoded instruction");

  chk_op_matches: assert property (@(posedge mclk) disable iff (!arst_n)
    decoded == (state_ff.op != flag_skip_pkg::op_none))
    else $error("decoded flag and operation disagree");

  chk_clears_exclusive: assert property (@(posedge mclk) disable iff (!arst_n)
    !(clear_conversion_done && clear_serial_request))
    else $error("both flag clears at once");
endmodule : flag_skip_test_instructions

//--- dv/test_flag_skip_test_instructions.sv
// Self-checking bench for the flag skip test decoder
`timescale 1ns/10ps
module test_flag_skip_test_instructions;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic instr_valid = 1'b0;
  logic [9:0] instr_opcode = 10'h000;
  logic [3:0] ctrl2 = 4'h0;
  logic [3:0] ctrl1 = 4'h0;
  // Conversion, serial, power-down, pin
  logic [3:0] flags = 4'h0;
  logic skip_next, clear_conversion_done, clear_serial_request, decoded, carry_write_en;
  logic [4:0] notes[$];
  logic [4:0] seen;
  logic [4:0] reset_seen;
  int num_errors = 0;
  int checks_done = 0;
  logic [9:0] opcodes[4] = '{flag_skip_pkg::OPC_CONV_DONE, flag_skip_pkg::OPC_EXT_PIN,
    flag_skip_pkg::OPC_POWERDOWN, flag_skip_pkg::OPC_SERIAL};

  flag_skip_test_instructions flag_skip_test_instructions_i (
    .mclk(mclk), .arst_n(arst_n), .instr_valid(instr_valid), .instr_opcode(instr_opcode),
    .second_irq_control_reg(ctrl2), .ext_irq_control_reg(ctrl1),
    .conversion_done_flag(flags[3]), .serial_request_flag(flags[2]),
    .powerdown_flag(flags[1]), .ext_pin_level(flags[0]), .skip_next(skip_next),
    .clear_conversion_done(clear_conversion_done), .clear_serial_request(clear_serial_request),
    .decoded(decoded), .carry_write_en(carry_write_en));

  // Order: skip, clear conversion, clear serial, decoded, carry write
  function automatic logic [4:0] model();
    logic [4:0] e;
    e = 5'h00;
    if (instr_valid)
      case (instr_opcode)
        flag_skip_pkg::OPC_CONV_DONE: e = {~ctrl2[2] & flags[3], ~ctrl2[2], 3'b010};
        flag_skip_pkg::OPC_EXT_PIN: e = {flags[0] == ctrl1[2], 4'b0010};
        flag_skip_pkg::OPC_POWERDOWN: e = {flags[1], 4'b0010};
        flag_skip_pkg::OPC_SERIAL: e = {~ctrl2[3] & flags[2], 1'b0, ~ctrl2[3], 2'b10};
        default: e = 5'h00;
      endcase
    return e;
  endfunction : model

  task automatic stop_test();
    $display("Checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  initial
  begin
    forever #5 mclk = ~mclk;
  end

  // Mostly the four opcodes; some random words to hit the refusal path
  initial
  begin
    void'($urandom(32'hCBE14C6A));
    repeat (20) @(posedge mclk);
    #1;
    reset_seen = {skip_next, clear_conversion_done, clear_serial_request, decoded, carry_write_en};
    checks_done++;
    if (reset_seen !== 5'h00)
    begin
      num_errors++;
      $display("[FAIL] reset outputs expected %b seen %b", 5'h00, reset_seen);
    end
    arst_n = 1'b1;
    repeat (800)
    begin
      @(posedge mclk);
      #1;
      instr_valid = ($urandom_range(0, 3) != 0);
      instr_opcode = ($urandom_range(0, 7) < 6) ? opcodes[$urandom_range(0, 3)] : 10'($urandom);
      ctrl2 = 4'($urandom);
      ctrl1 = 4'($urandom);
      flags = 4'($urandom);
      notes.push_back(model());
    end
    // Idle word so the last instruction's answer is compared too
    @(posedge mclk);
    #1;
    instr_valid = 1'b0;
    notes.push_back(model());
    repeat (3) @(posedge mclk);
    stop_test();
  end

  // Newest note belongs to the instruction not yet answered
  always @(posedge mclk)
  begin
    #2;
    if (notes.size() > 1)
    begin
      seen = {skip_next, clear_conversion_done, clear_serial_request, decoded, carry_write_en};
      checks_done++;
      if (seen !== notes[0])
      begin
        num_errors++;
        $display("[FAIL] outputs expected %b seen %b", notes[0], seen);
      end
      void'(notes.pop_front());
    end
  end

  initial
  begin
    #20000;
    num_errors++;
    stop_test();
  end
endmodule : test_flag_skip_test_instructions
